// ---- pkg/pbs_pkg.sv ----
package pbs_pkg;
    localparam int ADDR_W_DEF   = 16;
    localparam int LANES_DEF    = 4;
    localparam int LANE_W_DEF   = 8;
    localparam int BURST_LEN    = 4;
    localparam int BURST_BITS   = 2;
    // snooze exit window, ns, and its cycle count at 25 MHz
    localparam int CLK_PERIOD_NS          = 40;
    localparam int SNOOZE_EXIT_WINDOW_NS  = 200;
    localparam int SNOOZE_EXIT_CYCLES     = (SNOOZE_EXIT_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] BEAT_ZERO      = 2'h0;
    localparam logic [1:0] BEAT_ONE       = 2'h1;
    typedef enum logic [1:0] {PBS_IDLE, PBS_READ, PBS_WRITE} pbs_state_t;
endpackage

// ---- verilog/pbs_port.sv ----
`timescale 1ns/1ps
module pbs_port #(
    parameter int ADDR_W = pbs_pkg::ADDR_W_DEF,
    parameter int LANES  = pbs_pkg::LANES_DEF,
    parameter int LANE_W = pbs_pkg::LANE_W_DEF
) (
    input  wire logic                      clk_in,
    input  wire logic                      sys_rst_in,
    input  wire logic [ADDR_W-1:0]         addr_in,
    input  wire logic                      master_select_n_in,
    input  wire logic                      select_high_in,
    input  wire logic                      select_low_n_in,
    input  wire logic                      proc_addr_strobe_n_in,
    input  wire logic                      ctrl_addr_strobe_n_in,
    input  wire logic                      burst_step_n_in,
    input  wire logic                      global_write_n_in,
    input  wire logic                      byte_write_gate_n_in,
    input  wire logic [LANES-1:0]          lane_write_n_in,
    input  wire logic                      out_enable_n_in,
    input  wire logic                      burst_order_sel_in,
    input  wire logic                      burst_order_sel_oe_in,
    input  wire logic                      snooze_request_in,
    input  wire logic                      snooze_request_oe_in,
    input  wire logic [LANES*LANE_W-1:0]   dq_in,
    output logic      [LANES*LANE_W-1:0]   dq_out,
    output logic                           dq_oe_out,
    output logic                           snooze_exit_window_out
);
    localparam int DW = LANES * LANE_W;

    logic [DW-1:0]             mem [0:(1<<ADDR_W)-1];
    pbs_pkg::pbs_state_t       state_r;
    logic [ADDR_W-1:0]         base_r;
    logic [1:0]                start_r;
    logic [1:0]                beat_r;
    logic [DW-1:0]             rdata_r;
    logic                      rvalid_r;
    logic [DW-1:0]             wdata_r;
    logic [7:0]                exit_cnt_r;
    logic                      order_il;
    logic                      snooze;
    logic                      proc_start;
    logic                      ctrl_start;
    logic                      selected;
    logic                      any_strobe;
    logic                      advance;
    logic [LANES-1:0]          lane_wr;
    logic                      is_write;
    logic [1:0]                low_bits;
    logic [ADDR_W-1:0]         cur_addr;
    logic                      load_ok;
    pbs_pkg::pbs_state_t       state_nxt;
    logic [7:0]                since_wake_r;

    // weak pull-up and pull-down: an undriven pin takes the default level
    assign order_il = burst_order_sel_oe_in ? burst_order_sel_in : 1'b1;
    assign snooze   = snooze_request_oe_in ? snooze_request_in : 1'b0;

    function automatic logic [1:0] beat_addr(input logic [1:0] start, input logic [1:0] beat, input logic il);
        beat_addr = il ? (start ^ beat) : 2'(start + beat);
    endfunction

    assign selected   = select_high_in && !select_low_n_in;
    // every load needs all three selects, whichever strobe started it
    assign load_ok    = selected && !master_select_n_in;
    // master select blocks the processor strobe only
    assign proc_start = !proc_addr_strobe_n_in && !master_select_n_in;
    assign ctrl_start = !ctrl_addr_strobe_n_in && proc_addr_strobe_n_in;
    assign any_strobe = proc_start || ctrl_start;
    assign advance    = !burst_step_n_in && proc_addr_strobe_n_in && ctrl_addr_strobe_n_in;

    // per-lane write decode; processor-strobe edges never write
    always_comb begin
        lane_wr = '0;
        if (!global_write_n_in) begin
            lane_wr = '1;
        end else if (!byte_write_gate_n_in) begin
            lane_wr = ~lane_write_n_in;
        end
        if (proc_start) begin
            lane_wr = '0;
        end
    end
    assign is_write = |lane_wr;

    assign low_bits = beat_addr(start_r, beat_r, order_il);
    assign cur_addr = {base_r[ADDR_W-1:2], low_bits};

    // next operating state; snooze outranks the strobes, the strobes outrank the burst
    always_comb begin
        state_nxt = state_r;
        if (snooze) begin
            state_nxt = pbs_pkg::PBS_IDLE;
        end else if (any_strobe) begin
            if (load_ok) begin
                // write controls count only on a controller-strobe edge
                state_nxt = (ctrl_start && is_write) ? pbs_pkg::PBS_WRITE : pbs_pkg::PBS_READ;
            end else begin
                state_nxt = pbs_pkg::PBS_IDLE;              // standby
            end
        end else begin
            unique case (state_r)
                pbs_pkg::PBS_IDLE: begin
                    state_nxt = pbs_pkg::PBS_IDLE;
                end
                pbs_pkg::PBS_READ: begin
                    state_nxt = is_write ? pbs_pkg::PBS_WRITE : pbs_pkg::PBS_READ;
                end
                pbs_pkg::PBS_WRITE: begin
                    // a step with no write control turns the burst into a read
                    state_nxt = (is_write || !advance) ? pbs_pkg::PBS_WRITE : pbs_pkg::PBS_READ;
                end
                default: begin
                    state_nxt = pbs_pkg::PBS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            state_r <= pbs_pkg::PBS_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // burst position: loaded with the address, stepped by the advance input
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            base_r  <= '0;
            start_r <= pbs_pkg::BEAT_ZERO;
            beat_r  <= pbs_pkg::BEAT_ZERO;
        end else if (!snooze && any_strobe && load_ok) begin
            base_r  <= addr_in;
            start_r <= addr_in[1:0];
            beat_r  <= pbs_pkg::BEAT_ZERO;
        end else if (!snooze && !any_strobe && advance && state_r != pbs_pkg::PBS_IDLE) begin
            beat_r <= 2'(beat_r + pbs_pkg::BEAT_ONE);
        end
    end

    // array write: the address of the beat being taken now
    always_ff @(posedge clk_in) begin
        if (!snooze && is_write && (ctrl_start ? load_ok : (state_r != pbs_pkg::PBS_IDLE && !any_strobe))) begin
            for (int i = 0; i < LANES; i++) begin
                if (lane_wr[i]) begin
                    mem[ctrl_start ? addr_in : cur_addr][i*LANE_W +: LANE_W] <= dq_in[i*LANE_W +: LANE_W];
                end
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            wdata_r <= '0;
        end else if (!snooze && is_write) begin
            wdata_r <= dq_in;
        end
    end

    // read pipeline: address registered at one edge, data out the next
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rdata_r  <= '0;
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= !snooze && (state_r == pbs_pkg::PBS_READ) && !is_write;
            if (state_r == pbs_pkg::PBS_READ) begin
                rdata_r <= mem[cur_addr];
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            exit_cnt_r <= '0;
        end else if (snooze) begin
            exit_cnt_r <= 8'(pbs_pkg::SNOOZE_EXIT_CYCLES);
        end else if (exit_cnt_r != 8'h00) begin
            exit_cnt_r <= exit_cnt_r - 8'h01;
        end
    end

    assign snooze_exit_window_out = exit_cnt_r != 8'h00;
    assign dq_out    = rdata_r;
    // output enable acts without the clock; a write edge shuts the drivers
    assign dq_oe_out = !snooze && !out_enable_n_in && rvalid_r && !is_write;

    // helper for the exit-window check: edges since the snooze request fell, held at its top
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            since_wake_r <= 8'hff;
        end else if (snooze) begin
            since_wake_r <= 8'h00;
        end else if (since_wake_r != 8'hff) begin
            since_wake_r <= since_wake_r + 8'h01;
        end
    end

    chk_snooze_off: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        snooze |-> !dq_oe_out)
        else $error("drive during snooze");

    chk_oe_gate: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        out_enable_n_in |-> !dq_oe_out)
        else $error("drive without oe");

    chk_addr_load: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (!snooze && ctrl_start && load_ok) |=> base_r == $past(addr_in))
        else $error("address not loaded");

    chk_proc_block: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (master_select_n_in && ctrl_addr_strobe_n_in && !snooze && !advance) |=> $stable(beat_r))
        else $error("beat moved");

    chk_advance: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (!snooze && !any_strobe && advance && state_r != pbs_pkg::PBS_IDLE) |=> beat_r == 2'($past(beat_r) + 2'h1))
        else $error("no advance");

    chk_upper_fixed: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !any_strobe |=> $stable(base_r))
        else $error("upper bits moved");

    chk_global_wr: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (!global_write_n_in && !proc_start) |-> lane_wr == '1)
        else $error("global write");

    chk_read_mode: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (global_write_n_in && byte_write_gate_n_in) |-> !is_write)
        else $error("read decode");

    chk_exit_win: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        $fell(snooze) |-> snooze_exit_window_out)
        else $error("exit window");

    chk_ctrl_master: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (!snooze && ctrl_start && master_select_n_in) |=> (state_r == pbs_pkg::PBS_IDLE) && $stable(base_r))
        else $error("load with master select off");

    chk_proc_load: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (!snooze && proc_start && selected) |=> (state_r == pbs_pkg::PBS_READ) && (base_r == $past(addr_in)))
        else $error("processor strobe load");

    chk_standby: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (!snooze && any_strobe && !selected) |=> state_r == pbs_pkg::PBS_IDLE)
        else $error("no standby");

    chk_ctrl_write: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (!snooze && ctrl_start && load_ok && !global_write_n_in) |=> state_r == pbs_pkg::PBS_WRITE)
        else $error("controller write not taken");

    chk_byte_lanes: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (global_write_n_in && !byte_write_gate_n_in && !proc_start) |-> lane_wr == ~lane_write_n_in)
        else $error("lane write decode");

    chk_proc_lanes: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        proc_start |-> lane_wr == '0)
        else $error("write on processor strobe");

    chk_wdata_cap: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (!snooze && is_write) |=> wdata_r == $past(dq_in))
        else $error("write data not captured");

    chk_order_pull: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !burst_order_sel_oe_in |-> order_il)
        else $error("order select pull-up");

    chk_snooze_pull: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !snooze_request_oe_in |-> !snooze)
        else $error("snooze pull-down");

    chk_il_order: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (order_il && beat_r == 2'h3) |-> low_bits == ~start_r)
        else $error("interleaved order");

    chk_lin_order: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (!order_il && beat_r == 2'h1) |-> low_bits == 2'(start_r + 2'h1))
        else $error("linear order");

    chk_snooze_idle: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        snooze |=> state_r == pbs_pkg::PBS_IDLE)
        else $error("active during snooze");

    chk_snooze_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        snooze |=> $stable(base_r) && $stable(beat_r) && $stable(wdata_r))
        else $error("state moved in snooze");

    chk_read_valid: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (!snooze && state_r == pbs_pkg::PBS_READ && !is_write) |=> rvalid_r)
        else $error("read data not registered");

    chk_drive_read: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        dq_oe_out |-> $past(state_r) == pbs_pkg::PBS_READ)
        else $error("drive without a selected read");

    chk_write_off: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        is_write |-> !dq_oe_out)
        else $error("drive during write");

    chk_window_len: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        snooze_exit_window_out == (since_wake_r < 8'(pbs_pkg::SNOOZE_EXIT_CYCLES)))
        else $error("exit window length");

    chk_burst_wrap: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (!any_strobe && state_r != pbs_pkg::PBS_IDLE) |=> cur_addr[ADDR_W-1:2] == $past(cur_addr[ADDR_W-1:2]))
        else $error("burst left its group");

    chk_suspend: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (!snooze && !any_strobe && burst_step_n_in) |=> $stable(beat_r))
        else $error("beat moved without step");

    cov_read: cover property (@(posedge clk_in) dq_oe_out);
    cov_write: cover property (@(posedge clk_in) state_r == pbs_pkg::PBS_WRITE);
    cov_burst: cover property (@(posedge clk_in) beat_r == 2'h3);
    cov_snooze: cover property (@(posedge clk_in) $fell(snooze));
    cov_linear: cover property (@(posedge clk_in) !order_il && advance && state_r == pbs_pkg::PBS_READ);
endmodule

// ---- verification/pbs_host.sv ----
`timescale 1ns/1ps
module pbs_host (
    input wire logic clk_in
);
    logic [15:0] addr  = 16'h0000;
    logic [31:0] dq    = 32'h0000_0000;
    logic [2:0]  sel_n = 3'h5;
    logic        ps_n  = 1'h1;
    logic        cs_n  = 1'h1;
    logic        adv_n = 1'h1;
    logic [5:0]  wr_n  = 6'h3f;
    logic        oe_n  = 1'h1;
    logic [1:0]  order = 2'h0;
    logic [1:0]  snz   = 2'h0;
    // one strobe edge; afterwards the bus shows the inverse so a stale value never passes
    task automatic access(input logic p, input logic [2:0] s, input logic [5:0] w,
                          input logic [15:0] a, input logic [31:0] d);
        @(posedge clk_in);
        ps_n  <= !p;
        cs_n  <= p;
        sel_n <= s;
        wr_n  <= w;
        addr  <= a;
        dq    <= d;
        @(posedge clk_in);
        ps_n  <= 1'h1;
        cs_n  <= 1'h1;
        wr_n  <= 6'h3f;
        addr  <= ~a;
        dq    <= ~d;
    endtask
    task automatic step;
        @(posedge clk_in);
        adv_n <= 1'h0;
        @(posedge clk_in);
        adv_n <= 1'h1;
    endtask
endmodule

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    logic        clk_in     = 1'h0;
    logic        sys_rst_in = 1'h1;
    logic [31:0] dq_out;
    logic        dq_oe_out;
    logic        win;
    logic        prev_oe    = 1'h0;
    logic [31:0] exp_q[$];
    logic [31:0] mem[bit [15:0]];
    int          miscompares = 0;
    int          num_checks  = 0;
    logic [15:0] base;
    logic [31:0] d;
    logic [3:0]  ln;
    pbs_host host_u (.clk_in);
    pbs_port dut_u (.clk_in, .sys_rst_in, .addr_in(host_u.addr), .master_select_n_in(host_u.sel_n[2]),
        .select_high_in(host_u.sel_n[1]), .select_low_n_in(host_u.sel_n[0]),
        .proc_addr_strobe_n_in(host_u.ps_n), .ctrl_addr_strobe_n_in(host_u.cs_n),
        .burst_step_n_in(host_u.adv_n), .global_write_n_in(host_u.wr_n[5]),
        .byte_write_gate_n_in(host_u.wr_n[4]), .lane_write_n_in(host_u.wr_n[3:0]),
        .out_enable_n_in(host_u.oe_n), .burst_order_sel_in(host_u.order[1]),
        .burst_order_sel_oe_in(host_u.order[0]), .snooze_request_in(host_u.snz[1]),
        .snooze_request_oe_in(host_u.snz[0]), .dq_in(host_u.dq), .dq_out, .dq_oe_out,
        .snooze_exit_window_out(win));
    initial forever #20 clk_in = ~clk_in;
    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t data %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp1(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        if (miscompares == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // output enable opens once per read, so each rising drive enable is one result
    task automatic show(input logic [31:0] e);
        exp_q.push_back(e);
        repeat (3) @(posedge clk_in);
        host_u.oe_n <= 1'h0;
        repeat (2) @(posedge clk_in);
        host_u.oe_n <= 1'h1;
    endtask
    always @(negedge clk_in) begin
        if (dq_oe_out === 1'h1 && prev_oe !== 1'h1) begin
            if (exp_q.size() == 0) begin
                miscompares++;
                $display("ERROR %0t pins driven with no read pending", $time);
            end else cmp32(dq_out, exp_q.pop_front());
        end
        prev_oe = dq_oe_out;
    end
    initial begin
        repeat (3000) @(posedge clk_in);
        miscompares++;
        end_of_test();
    end
    initial begin
        void'($urandom(7));
        repeat (12) @(posedge clk_in);
        sys_rst_in <= 1'h0;
        @(negedge clk_in);
        cmp1(dq_oe_out, 1'h0);
        cmp32(dq_out, 32'h0000_0000);
        cmp1(win, 1'h0);
        @(posedge clk_in);
        host_u.oe_n <= 1'h0;
        for (int i = 0; i < 16; i++)
            if (i[2:0] != 3'h2) host_u.access(i[3], i[2:0], 6'h3f, 16'($urandom), 32'h0000_0000);
        host_u.oe_n <= 1'h1;
        base = 16'($urandom) & 16'hfffc;
        for (int k = 0; k < 4; k++) begin
            d = $urandom;
            mem[base + 16'(k)] = d;
            host_u.access(1'h0, 3'h2, {1'h0, 5'($urandom)}, base + 16'(k), d);
        end
        d = $urandom;
        ln = 4'($urandom) & 4'he;
        host_u.access(1'h0, 3'h2, {2'h2, ln}, base + 16'h0001, d);
        for (int j = 0; j < 4; j++) if (!ln[j]) mem[base + 16'h0001][8*j +: 8] = d[8*j +: 8];
        host_u.access(1'h0, 3'h2, 6'h30, base + 16'h0001, ~d);
        show(mem[base + 16'h0001]);
        for (int m = 0; m < 8; m++) begin
            host_u.order <= {1'h0, m[2]};
            host_u.access(m[0], 3'h2, 6'h3f, base + 16'(m[1:0]), 32'h0000_0000);
            for (int k = 0; k < 4; k++) begin
                if (k > 0) host_u.step();
                show(mem[{base[15:2], m[2] ? 2'(m[1:0] + k) : 2'(m[1:0] ^ k)}]);
            end
        end
        host_u.access(1'h0, 3'h2, 6'h3f, base, 32'h0000_0000);
        exp_q.push_back(mem[base]);
        repeat (3) @(posedge clk_in);
        host_u.oe_n <= 1'h0;
        repeat (2) @(posedge clk_in);
        host_u.snz <= 2'h3;
        @(negedge clk_in);
        cmp1(dq_oe_out, 1'h0);
        @(posedge clk_in);
        host_u.oe_n <= 1'h1;
        host_u.access(1'h0, 3'h2, 6'h1f, base, ~mem[base]);
        host_u.snz <= 2'h0;
        repeat (2) @(posedge clk_in);
        @(negedge clk_in);
        cmp1(win, 1'h1);
        host_u.access(1'h0, 3'h2, 6'h3f, base, 32'h0000_0000);
        show(mem[base]);
        @(negedge clk_in);
        cmp1(win, 1'h0);
        end_of_test();
    end
endmodule
